// *** rtl/plce_defines.vh ***
// constants for the preload channel control block
`ifndef PLCE_DEFINES_VH
`define PLCE_DEFINES_VH
`define PLCE_CRN_C11      4'hb
`define PLCE_CRM_FLUSH    4'h2
`define PLCE_CRM_CHAN     4'h3
`define PLCE_OP2_FLUSH    3'h1
`define PLCE_OP2_PAUSE    3'h0
`define PLCE_OP2_RESUME   3'h1
`define PLCE_OP2_KILL     3'h2
`define PLCE_BASE_HI      63
`define PLCE_BASE_LO      34
`define PLCE_LEN_HI       31
`define PLCE_LEN_LO       18
`define PLCE_STR_HI       17
`define PLCE_STR_LO       10
`define PLCE_CNT_HI       9
`define PLCE_CNT_LO       2
`define PLCE_LINE_WORDS   14'h0008
`define PLCE_WB_CTRL      4'h0
`define PLCE_WB_STAT      4'h4
`define PLCE_WB_CFG       4'h8
`define PLCE_CTRL_NSP     0
`define PLCE_CTRL_USR     1
`define PLCE_DEPTH_DEF    16
`endif

// *** rtl/plce_preload_ctrl.v ***
// preload engine channel control with command decode, descriptor fifo and line issuer
//
// Contract
// - non-secure needs permit, user needs enable bit
// - engine absent: preload ops raise undefined
// - flush op discards fifo and active channel
// - pause op halts activity, even when idle
// - paused engine starts no channel until resume
// - resume restarts; resume when running ignored
// - kill op ends only active channel
// - program op queues descriptor, kills active channel
// - base from bits 63:34, low bits zero
// - bits 31:18 length, n means n+1 words
// - bits 17:10 stride in words between blocks
// - bits 9:2 block count minus one
// - append descriptor while fifo has room
// - full fifo drops descriptor, overflow event pulses
// - depth 16/8/4; entry keeps valid, ns, base, address_space_id
// - translation abort drops line, continue next
// - translation register write flushes everything
// - tlb invalidate by address_space_id matches; all flushes
`timescale 1ns/10ps
`include "plce_defines.vh"
module plce_preload_ctrl #(
  parameter DEPTH      = `PLCE_DEPTH_DEF,
  parameter PRESENT    = 1,
  parameter TTB_W      = 18,
  parameter ADDRESS_SPACE_ID_W     = 8
) (
  input  wire              clk_i,          // core clock
  input  wire              rst_i,          // sync reset, high
  // core command side
  input  wire              cmd_valid_i,    // mcr/mcrr op to c11
  input  wire              cmd_pair_i,     // two-register transfer
  input  wire [3:0]        cmd_crn_i,      // crn field
  input  wire [3:0]        cmd_crm_i,      // crm field
  input  wire [2:0]        cmd_op2_i,      // opcode2 field
  input  wire [31:0]       upper_operand_reg_i, // base word
  input  wire [31:0]       lower_operand_reg_i, // len/stride/count word
  input  wire              cur_ns_i,       // core non-secure
  input  wire              cur_user_i,     // core in user mode
  input  wire [TTB_W-1:0]  cur_ttb_i,      // current translation base
  input  wire [ADDRESS_SPACE_ID_W-1:0] cur_address_space_id_i,     // current address space id
  // translation maintenance
  input  wire              xlat_reg_wr_i,  // domain/remap/ap register write
  input  wire              tlb_inv_address_space_id_i, // invalidate by address_space_id or mva+address_space_id
  input  wire              tlb_inv_all_i,  // invalidate all variants
  input  wire [ADDRESS_SPACE_ID_W-1:0] tlb_address_space_id_i,     // address_space_id of invalidate
  // level-2 request side
  input  wire              req_ready_i,    // l2 takes line request
  input  wire              req_abort_i,    // translation abort on request
  // status and request outputs
  output wire              cmd_undef_o,    // undefined instruction
  output wire              req_valid_o,    // line request valid
  output reg  [31:0]       req_addr_o,     // line virtual address
  output reg               req_ns_o,       // request security state
  output reg  [TTB_W-1:0]  req_ttb_o,      // request translation base
  output reg  [ADDRESS_SPACE_ID_W-1:0] req_address_space_id_o,     // request address space id
  output reg               ovf_evt_o,      // fifo overflow pulse
  output wire              paused_o,       // engine paused
  output wire              active_o,       // channel active
  output wire [4:0]        fifo_count_o,   // entries queued
  // register bus
  input  wire              wb_cyc_i,       // wishbone cycle
  input  wire              wb_stb_i,       // wishbone strobe
  input  wire              wb_we_i,        // wishbone write
  input  wire [3:0]        wb_adr_i,       // wishbone byte address
  input  wire [3:0]        wb_sel_i,       // wishbone byte enables
  input  wire [31:0]       wb_dat_i,       // wishbone write data
  output reg  [31:0]       wb_dat_o,       // wishbone read data
  output reg               wb_ack_o        // wishbone ack
);
  localparam AW = (DEPTH > 8) ? 4 : (DEPTH > 4) ? 3 : 2;
  localparam EW = 30 + 14 + 8 + 8 + 1 + TTB_W + ADDRESS_SPACE_ID_W;
  localparam S_IDLE = 3'h1;
  localparam S_RUN  = 3'h2;
  localparam S_NEXT = 3'h4;

  // software control bits and channel state
  reg              nsp_reg;
  reg              usr_reg;
  reg              paused_reg;
  reg  [2:0]       state_reg;
  reg  [2:0]       state_next;

  // fifo storage, with a per-entry valid so invalidates can punch holes
  reg  [EW-1:0]    mem_reg [0:DEPTH-1];
  reg  [DEPTH-1:0] vld_reg;
  reg  [AW-1:0]    rd_reg;
  reg  [AW-1:0]    wr_reg;
  reg  [4:0]       cnt_reg;

  // active channel
  reg  [29:0]      a_base_reg;
  reg  [13:0]      a_len_reg;
  reg  [7:0]       a_str_reg;
  reg  [7:0]       a_blk_reg;
  reg  [13:0]      a_off_reg;
  reg  [31:0]      a_bstart_reg;

  // command decode; a refused op only raises undefined and changes nothing
  wire is_c11  = cmd_valid_i && (cmd_crn_i == `PLCE_CRN_C11);
  wire allowed = (!cur_ns_i || nsp_reg) && (!cur_user_i || usr_reg);
  wire denied  = is_c11 && (PRESENT == 0 || !allowed);
  assign cmd_undef_o = denied;
  wire go      = is_c11 && !denied;
  wire op_flush  = go && !cmd_pair_i && cmd_crm_i == `PLCE_CRM_FLUSH
                   && cmd_op2_i == `PLCE_OP2_FLUSH;
  wire op_pause  = go && !cmd_pair_i && cmd_crm_i == `PLCE_CRM_CHAN
                   && cmd_op2_i == `PLCE_OP2_PAUSE;
  wire op_resume = go && !cmd_pair_i && cmd_crm_i == `PLCE_CRM_CHAN
                   && cmd_op2_i == `PLCE_OP2_RESUME;
  wire op_kill   = go && !cmd_pair_i && cmd_crm_i == `PLCE_CRM_CHAN
                   && cmd_op2_i == `PLCE_OP2_KILL;
  wire op_prog   = go && cmd_pair_i;

  wire flush_all = op_flush || xlat_reg_wr_i || tlb_inv_all_i;

  // operand fields; the two ignored bit groups never enter storage
  wire [63:0] opnd   = {upper_operand_reg_i, lower_operand_reg_i};
  wire [29:0] f_base = opnd[`PLCE_BASE_HI:`PLCE_BASE_LO];
  wire [13:0] f_len  = opnd[`PLCE_LEN_HI:`PLCE_LEN_LO];
  wire [7:0]  f_str  = opnd[`PLCE_STR_HI:`PLCE_STR_LO];
  wire [7:0]  f_cnt  = opnd[`PLCE_CNT_HI:`PLCE_CNT_LO];
  wire [EW-1:0] new_ent = {f_base, f_len, f_str, f_cnt, cur_ns_i, cur_ttb_i, cur_address_space_id_i};

  wire full  = (cnt_reg == DEPTH);
  wire push  = op_prog && !full && !flush_all;
  wire [EW-1:0] head = mem_reg[rd_reg];
  wire head_v = vld_reg[rd_reg];
  wire [ADDRESS_SPACE_ID_W-1:0] head_address_space_id = head[ADDRESS_SPACE_ID_W-1:0];
  wire [TTB_W-1:0]  head_ttb  = head[ADDRESS_SPACE_ID_W+TTB_W-1:ADDRESS_SPACE_ID_W];
  wire head_ns = head[ADDRESS_SPACE_ID_W+TTB_W];

  wire [29:0] head_base = head[EW-1:EW-30];
  wire [13:0] head_len  = head[EW-31:EW-44];
  wire [7:0]  head_str  = head[EW-45:EW-52];
  wire [7:0]  head_cnt  = head[EW-53:EW-60];

  wire in_idle    = (state_reg == S_IDLE);
  wire in_run     = (state_reg == S_RUN);
  wire any_queued = (cnt_reg != 5'h00);

  wire kill_act = op_kill || op_prog || flush_all
                  || (tlb_inv_address_space_id_i && req_address_space_id_o == tlb_address_space_id_i);
  wire can_start = in_idle && !paused_reg && any_queued
                   && !flush_all && !kill_act;
  // invalidated heads drain even while paused, they never start a walk
  wire pop = can_start || (in_idle && any_queued && !head_v && !flush_all);

  // held low while paused so the walk picks up where it stopped
  assign req_valid_o  = in_run && !paused_reg;
  assign paused_o     = paused_reg;
  assign active_o     = (state_reg != S_IDLE);
  assign fifo_count_o = cnt_reg;

  wire line_done = req_valid_o && (req_ready_i || req_abort_i);
  wire [14:0] off_step = {1'b0, a_off_reg} + {1'b0, `PLCE_LINE_WORDS};
  wire blk_end = ({1'b0, a_off_reg} + {1'b0, `PLCE_LINE_WORDS}) > {1'b0, a_len_reg};
  wire last_blk = (a_blk_reg == 8'h00);

  // stride 0 means contiguous: next block follows this one; the length is
  // widened before the add so a 16K-word block does not wrap to zero
  wire [31:0] gap_contig = {16'h0000, a_len_reg, 2'h0} + 32'h00000004;
  wire [31:0] gap_stride = {22'h000000, a_str_reg, 2'h0};
  wire [31:0] block_gap  = (a_str_reg == 8'h00) ? gap_contig : gap_stride;
  wire ovf_hit = op_prog && full && !flush_all;

  wire [AW-1:0] wr_inc = (wr_reg == DEPTH-1) ? {AW{1'b0}} : wr_reg + 1'b1;
  wire [AW-1:0] rd_inc = (rd_reg == DEPTH-1) ? {AW{1'b0}} : rd_reg + 1'b1;

  // pause state; resume outside pause has nothing to undo
  always @(posedge clk_i) begin
    if (rst_i) begin
      paused_reg <= 1'b0;
    end else if (op_pause) begin
      paused_reg <= 1'b1;
    end else if (op_resume) begin
      paused_reg <= 1'b0;
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (can_start && head_v)
          state_next = S_RUN;
      end
      S_RUN: begin
        if (line_done && blk_end)
          state_next = last_blk ? S_IDLE : S_NEXT;
      end
      S_NEXT: begin
        state_next = S_RUN;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    // a kill overrides any transition above; the channel is idle from the cycle after the op
    if (kill_act && state_reg != S_IDLE) begin
      state_next = S_IDLE;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // channel walk: lines within a block, then base advances by stride
  always @(posedge clk_i) begin
    if (rst_i) begin
      a_base_reg   <= 30'h00000000;
      a_len_reg    <= 14'h0000;
      a_str_reg    <= 8'h00;
      a_blk_reg    <= 8'h00;
      a_off_reg    <= 14'h0000;
      a_bstart_reg <= 32'h00000000;
      req_addr_o   <= 32'h00000000;
      req_ns_o     <= 1'b0;
      req_ttb_o    <= {TTB_W{1'b0}};
      req_address_space_id_o   <= {ADDRESS_SPACE_ID_W{1'b0}};
    end else if (state_reg == S_IDLE && can_start && head_v) begin
      // start: latch the head descriptor and its context
      a_base_reg   <= head_base;
      a_len_reg    <= head_len;
      a_str_reg    <= head_str;
      a_blk_reg    <= head_cnt;
      a_off_reg    <= 14'h0000;
      a_bstart_reg <= {head_base, 2'h0};
      req_addr_o   <= {head_base, 2'h0};
      req_ns_o     <= head_ns;
      req_ttb_o    <= head_ttb;
      req_address_space_id_o   <= head_address_space_id;
    end else if (state_reg == S_RUN && line_done && !blk_end) begin
      // next line inside the block; an aborted line still advances
      a_off_reg  <= off_step[13:0];
      req_addr_o <= a_bstart_reg + {16'h0000, off_step[13:0], 2'h0};
    end else if (state_reg == S_RUN && line_done) begin
      // block done: move the block start on by the gap
      a_bstart_reg <= a_bstart_reg + block_gap;
      a_blk_reg    <= a_blk_reg - 8'h01;
      a_off_reg    <= 14'h0000;
    end else if (state_reg == S_NEXT) begin
      // one idle cycle between blocks, then the first line of the next
      req_addr_o <= a_bstart_reg;
    end
  end

  // fifo pointers and overflow event
  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_reg    <= {AW{1'b0}};
      wr_reg    <= {AW{1'b0}};
      cnt_reg   <= 5'h00;
      ovf_evt_o <= 1'b0;
    end else begin
      ovf_evt_o <= ovf_hit;
      // a flush beats a program in the same cycle, the descriptor is lost
      if (flush_all) begin
        rd_reg  <= {AW{1'b0}};
        wr_reg  <= {AW{1'b0}};
        cnt_reg <= 5'h00;
      end else begin
        if (push) begin
          wr_reg <= wr_inc;
        end
        if (pop) begin
          rd_reg <= rd_inc;
        end
        cnt_reg <= cnt_reg + {4'h0, push} - {4'h0, pop};
      end
    end
  end

  // per-entry valid and storage, one slice per entry
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
      always @(posedge clk_i) begin
        // a push into this slot beats an invalidate of its old contents
        if (rst_i) begin
          vld_reg[gi] <= 1'b0;
        end else if (flush_all) begin
          vld_reg[gi] <= 1'b0;
        end else if (push && wr_reg == gi) begin
          vld_reg[gi] <= 1'b1;
        end else if (tlb_inv_address_space_id_i && mem_reg[gi][ADDRESS_SPACE_ID_W-1:0] == tlb_address_space_id_i) begin
          vld_reg[gi] <= 1'b0;
        end else if (pop && rd_reg == gi) begin
          vld_reg[gi] <= 1'b0;
        end
      end
      always @(posedge clk_i) begin
        if (push && wr_reg == gi) begin
          mem_reg[gi] <= new_ent;
        end
      end
    end
  endgenerate

  // wishbone slave: one wait-free ack per request
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire ctrl_wr = wb_req && wb_we_i && wb_adr_i == `PLCE_WB_CTRL && wb_sel_i[0];

  // read mux kept combinational so the data flop loads in the request cycle
  reg  [31:0]      rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      `PLCE_WB_CTRL: rd_mux = {30'h00000000, usr_reg, nsp_reg};
      `PLCE_WB_STAT: rd_mux = {24'h000000, cnt_reg, full, active_o, paused_reg};
      `PLCE_WB_CFG:  rd_mux = DEPTH;
      default:       rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      nsp_reg  <= 1'b0;
      usr_reg  <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      if (ctrl_wr) begin
        nsp_reg <= wb_dat_i[`PLCE_CTRL_NSP];
        usr_reg <= wb_dat_i[`PLCE_CTRL_USR];
      end
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end
endmodule

// *** tb/l2_preload_channel_control_tb.sv ***
// self-checking bench for the preload channel control
`timescale 1ns/10ps
`define CHK(n, g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module l2_preload_channel_control_tb;
  localparam DEPTH = 4;
  logic clk_i = 0, rst_i = 1, cmd_valid_i = 0, cmd_pair_i = 0, cur_ns_i = 0, cur_user_i = 0;
  logic xlat_reg_wr_i = 0, tlb_inv_address_space_id_i = 0, tlb_inv_all_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic wb_we_i = 0, req_ready_i, req_abort_i, abort_en = 0;
  logic [3:0] cmd_crn_i = 4'hb, cmd_crm_i = 0, wb_adr_i = 0, wb_sel_i = 4'hf;
  logic [2:0] cmd_op2_i = 0;
  logic [31:0] upper_operand_reg_i = 0, lower_operand_reg_i = 0, wb_dat_i = 0;
  logic [31:0] wb_dat_o, req_addr_o, rd;
  logic [17:0] cur_ttb_i = 0, req_ttb_o;
  logic [7:0] cur_address_space_id_i = 0, tlb_address_space_id_i = 0, req_address_space_id_o;
  logic [7:0] address_space_id_v = 8'h5a;
  logic [17:0] ttb_v = 18'h00000;
  logic cmd_undef_o, req_valid_o, req_ns_o, ovf_evt_o, paused_o, active_o, wb_ack_o;
  logic [4:0] fifo_count_o;
  logic [31:0] exp_q[$];
  int failures = 0, checked = 0, cyc = 0;
  plce_preload_ctrl #(.DEPTH(DEPTH)) dut (.clk_i, .rst_i, .cmd_valid_i, .cmd_pair_i,
    .cmd_crn_i, .cmd_crm_i, .cmd_op2_i, .upper_operand_reg_i, .lower_operand_reg_i, .cur_ns_i,
    .cur_user_i, .cur_ttb_i, .cur_address_space_id_i, .xlat_reg_wr_i, .tlb_inv_address_space_id_i, .tlb_inv_all_i,
    .tlb_address_space_id_i, .req_ready_i, .req_abort_i, .cmd_undef_o, .req_valid_o, .req_addr_o, .req_ns_o,
    .req_ttb_o, .req_address_space_id_o, .ovf_evt_o, .paused_o, .active_o, .fifo_count_o, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  plce_l2_model l2 (.clk_i, .req_valid_i(req_valid_o), .req_addr_i(req_addr_o),
    .abort_en_i(abort_en), .req_ready_o(req_ready_i), .req_abort_o(req_abort_i));
  initial forever #4 clk_i = ~clk_i;
  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard well above the longest walk
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin failures++; final_report(); end
  end
  task automatic op(input logic p, input logic [3:0] m, input logic [2:0] o,
                    input logic [31:0] u, l, input logic ns, us, eu);
    @(posedge clk_i);
    {cmd_valid_i, cmd_pair_i, cmd_crm_i, cmd_op2_i} <= {1'b1, p, m, o};
    {upper_operand_reg_i, lower_operand_reg_i, cur_ns_i, cur_user_i} <= {u, l, ns, us};
    cur_address_space_id_i <= address_space_id_v;
    cur_ttb_i <= ttb_v;
    #2 `CHK("undef", cmd_undef_o, eu)
    @(posedge clk_i);
    cmd_valid_i <= 0;
  endtask
  task automatic cmd(input logic [3:0] m, input logic [2:0] o);
    op(0, m, o, $urandom, $urandom, 0, 0, 0);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  function automatic void lines(input logic [31:0] u, l);
    int len, gap;
    len = (int'(l[31:18]) + 1) * 4;
    gap = l[17:10] == 0 ? len : int'(l[17:10]) * 4;
    for (int b = 0; b <= int'(l[9:2]); b++)
      for (int o = 0; o < len; o += 32) exp_q.push_back({u[31:2], 2'b00} + b * gap + o);
  endfunction
  task automatic run(input logic [31:0] u, l, input logic pz);
    int n;
    exp_q.delete();
    lines(u, l);
    l2.seen_q.delete();
    address_space_id_v = $urandom;
    ttb_v = $urandom;
    op(1, 4'h0, 3'h0, u, l, 0, 0, 0);
    if (pz) begin
      repeat (10) @(posedge clk_i);
      `CHK("held", {paused_o, active_o, fifo_count_o}, 7'h41)
      cmd(4'h3, 3'h1);
    end
    n = 0;
    while (l2.seen_q.size() < exp_q.size() && n < 4000) begin @(posedge clk_i); n++; end
    repeat (20) @(posedge clk_i);
    `CHK("lines", l2.seen_q.size(), exp_q.size())
    `CHK("ctx", {req_ns_o, req_ttb_o, req_address_space_id_o}, {1'b0, ttb_v, address_space_id_v})
    foreach (exp_q[i]) if (i < l2.seen_q.size()) `CHK("addr", l2.seen_q[i], exp_q[i])
  endtask
  initial begin
    void'($urandom(83025));
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 4'h0, 0); `CHK("ctrl", rd, 32'h0)
    wb(0, 4'h8, 0); `CHK("cfg", rd, 32'h4)
    wb(0, 4'hc, 0); `CHK("unmapped", rd, 32'h0)
    op(0, 4'h3, 3'h1, 0, 0, 1, 0, 1);
    op(0, 4'h3, 3'h1, 0, 0, 0, 1, 1);
    wb(1, 4'h0, 32'h3);
    wb(0, 4'h0, 0); `CHK("ctrl", rd, 32'h3)
    op(0, 4'h3, 3'h1, 0, 0, 1, 1, 0);
    $display("test access done");
    cmd(4'h3, 3'h0);
    run(32'h1000_0007, 32'h0010_0c0b, 1);
    abort_en <= 1;
    // small random regions keep each walk short
    repeat (8) run($urandom, {14'($urandom_range(40)), 8'($urandom_range(15)),
                              8'($urandom_range(2)), 2'($urandom)}, 0);
    run(32'h2000_0003, {14'h0, 8'h1, 8'hff, 2'b11}, 0);
    $display("test walk done");
    cmd(4'h3, 3'h0);
    repeat (DEPTH + 1) op(1, 4'h0, 3'h0, $urandom, 32'hfffc_0000, 0, 0, 0);
    #1 `CHK("ovf", ovf_evt_o, 1'b1)
    `CHK("full", fifo_count_o, 5'(DEPTH))
    cmd(4'h3, 3'h1);
    repeat (4) @(posedge clk_i);
    `CHK("popped", {active_o, fifo_count_o}, {1'b1, 5'(DEPTH - 1)})
    cmd(4'h3, 3'h2);
    #1 `CHK("killed", {active_o, fifo_count_o}, {1'b0, 5'(DEPTH - 1)})
    cmd(4'h2, 3'h1);
    repeat (2) @(posedge clk_i);
    `CHK("flushed", {active_o, fifo_count_o}, 6'h00)
    for (int k = 0; k < 3; k++) begin
      cmd(4'h3, 3'h0);
      repeat (2) op(1, 4'h0, 3'h0, $urandom, 32'hfffc_0000, 0, 0, 0);
      @(posedge clk_i);
      if (k == 0) xlat_reg_wr_i <= 1;
      else if (k == 1) tlb_inv_all_i <= 1;
      else {tlb_inv_address_space_id_i, tlb_address_space_id_i} <= {1'b1, address_space_id_v};
      @(posedge clk_i);
      {xlat_reg_wr_i, tlb_inv_all_i, tlb_inv_address_space_id_i} <= 3'b000;
      repeat (3) @(posedge clk_i);
      `CHK("dropped", {active_o, fifo_count_o}, 6'h00)
      cmd(4'h3, 3'h1);
    end
    $display("test queue done");
    final_report();
  end
endmodule

// *** tb/plce_l2_model.sv ***
// level-2 side model: takes line requests with random stalls and aborts
`timescale 1ns/10ps
module plce_l2_model (
  input  wire        clk_i,       // core clock
  input  wire        req_valid_i, // line request
  input  wire [31:0] req_addr_i,  // line address
  input  wire        abort_en_i,  // allow translation aborts
  output reg         req_ready_o, // line taken
  output reg         req_abort_o  // line aborted
);
  logic [31:0] seen_q[$];
  logic [31:0] r;
  initial begin
    req_ready_o = 1'b0;
    req_abort_o = 1'b0;
  end
  // aborted lines are logged too: the walk must still advance past them
  always @(posedge clk_i) begin
    if (req_valid_i && (req_ready_o || req_abort_o))
      seen_q.push_back(req_addr_i);
    r = $urandom;
    req_ready_o <= r[1:0] != 2'b00;
    req_abort_o <= abort_en_i && r[4:2] == 3'b000;
  end
endmodule

// *** tb/plce_preload_ctrl_properties.sv ***
// port checker for the preload channel control
`timescale 1ns/10ps
module plce_preload_ctrl_properties #(parameter DEPTH = 16) (
  input wire       clk_i, rst_i, cmd_valid_i, cmd_pair_i, xlat_reg_wr_i, tlb_inv_all_i, // ctl
  input wire [3:0] cmd_crn_i, cmd_crm_i,                      // op fields
  input wire [2:0] cmd_op2_i,                                 // opcode2
  input wire       cmd_undef_o, ovf_evt_o, paused_o, active_o, // status
  input wire [4:0] fifo_count_o,                              // queued
  input wire       wb_cyc_i, wb_stb_i, wb_ack_o               // bus
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire go = cmd_valid_i && !cmd_undef_o && cmd_crn_i == 4'hb;
  wire chan = go && !cmd_pair_i && cmd_crm_i == 4'h3;
  wire prog = go && cmd_pair_i;
  sequence wb_req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence wb_ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence gone_s; fifo_count_o == 5'h00 && !active_o; endsequence
  flush_op_a: assert property (go && !cmd_pair_i && cmd_crm_i == 4'h2 && cmd_op2_i == 3'h1
    |=> gone_s) else $error("flush kept work");
  pause_op_a: assert property (chan && cmd_op2_i == 3'h0 |=> paused_o)
    else $error("pause not taken");
  pause_hold_a: assert property (paused_o && !active_o && !(chan && cmd_op2_i == 3'h1)
    |=> !active_o) else $error("channel started while paused");
  resume_op_a: assert property (chan && cmd_op2_i == 3'h1 |=> !paused_o)
    else $error("resume not taken");
  kill_only_a: assert property (chan && cmd_op2_i == 3'h2 && active_o
    |=> !active_o && fifo_count_o == $past(fifo_count_o)) else $error("kill touched queue");
  xlat_flush_a: assert property (xlat_reg_wr_i || tlb_inv_all_i |=> gone_s)
    else $error("translation change kept work");
  ovf_event_a: assert property (prog && paused_o && fifo_count_o == DEPTH |=> ovf_evt_o)
    else $error("overflow event missing");
  wb_ack_a: assert property (wb_req_s |=> wb_ack_s) else $error("bus ack not one cycle");
endmodule
bind plce_preload_ctrl plce_preload_ctrl_properties #(.DEPTH(DEPTH)) u_prop (.clk_i, .rst_i,
  .cmd_valid_i, .cmd_pair_i, .xlat_reg_wr_i, .tlb_inv_all_i, .cmd_crn_i, .cmd_crm_i,
  .cmd_op2_i, .cmd_undef_o, .ovf_evt_o, .paused_o, .active_o, .fifo_count_o, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o);
